// [tws_regs.svh]
// Purpose: offsets, reset values, status codes and divisors
// Assumes: byte addresses on a 32-bit avalon slave
// Notes:   definitions only
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

`define TWS_AW          5
`define TWS_OFS_CTL     5'h00
`define TWS_OFS_STAT    5'h04
`define TWS_OFS_DAT     5'h08
`define TWS_OFS_OWN     5'h0C

`define TWS_CTL_RST     8'h00
`define TWS_OWN_RST     8'h00
`define TWS_DAT_RST     8'h00
`define TWS_GC_ADDR     8'h00

`define TWS_ST_NONE     8'hF8
`define TWS_ST_START    8'h08
`define TWS_ST_RSTART   8'h10
`define TWS_ST_AW_ACK   8'h18
`define TWS_ST_AW_NACK  8'h20
`define TWS_ST_DT_ACK   8'h28
`define TWS_ST_DT_NACK  8'h30
`define TWS_ST_ARB      8'h38
`define TWS_ST_AR_ACK   8'h40
`define TWS_ST_AR_NACK  8'h48
`define TWS_ST_DR_ACK   8'h50
`define TWS_ST_DR_NACK  8'h58
`define TWS_ST_SW       8'h60
`define TWS_ST_SW_ARB   8'h68
`define TWS_ST_GC       8'h70
`define TWS_ST_GC_ARB   8'h78
`define TWS_ST_SD_ACK   8'h80
`define TWS_ST_SD_NACK  8'h88
`define TWS_ST_GD_ACK   8'h90
`define TWS_ST_GD_NACK  8'h98

`define TWS_BIT_LAST    4'h8

`define TWS_DIV_0       12'h100
`define TWS_DIV_1       12'h0E0
`define TWS_DIV_2       12'h0C0
`define TWS_DIV_3       12'h0A0
`define TWS_DIV_4       12'h3C0
`define TWS_DIV_5       12'h078
`define TWS_DIV_6       12'h03C

`endif

// [tws_pkg.sv]
// Purpose: shared types of the two-wire serial unit
// Assumes: nothing
// Notes:   control layout matches the control register bits 7..0
package tws_pkg;

	typedef struct packed {
		logic cr2;
		logic en;
		logic start_request;
		logic stop_request;
		logic si;
		logic aa;
		logic cr1;
		logic cr0;
	} tws_ctl_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic rise;
		logic fall;
		logic start;
		logic stop;
	} tws_ev_t;

	typedef enum logic [2:0] {
		S_IDLE   = 3'h0,
		S_START  = 3'h1,
		S_HOLD   = 3'h3,
		S_BYTE   = 3'h2,
		S_STOP   = 3'h6,
		S_RSTART = 3'h7
	} tws_state_t;

endpackage : tws_pkg

// [tws_pin_sync.sv]
// Purpose: synchronise scl/sda and find edges, start and stop
// Assumes: pins idle high
// Notes:   events lag the pins by two clocks
`timescale 1ns/1ps
module tws_pin_sync (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic         scl_i,
	input  wire logic         sda_i,
	output tws_pkg::tws_ev_t  ev_o
);
	logic [1:0] scl_ff_r;
	logic [1:0] sda_ff_r;
	logic       scl_d_r;
	logic       sda_d_r;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			scl_ff_r <= 2'h3;
			sda_ff_r <= 2'h3;
			scl_d_r  <= 1'b1;
			sda_d_r  <= 1'b1;
		end
		else if (ce_i)
		begin
			scl_ff_r <= {scl_ff_r[0], scl_i};
			sda_ff_r <= {sda_ff_r[0], sda_i};
			scl_d_r  <= scl_ff_r[1];
			sda_d_r  <= sda_ff_r[1];
		end
	end

	// only the second stage and its delayed copy feed logic
	assign ev_o.scl   = scl_ff_r[1];
	assign ev_o.sda   = sda_ff_r[1];
	assign ev_o.rise  = scl_ff_r[1] & ~scl_d_r;
	assign ev_o.fall  = ~scl_ff_r[1] & scl_d_r;
	assign ev_o.start = scl_ff_r[1] & scl_d_r & sda_d_r & ~sda_ff_r[1];
	assign ev_o.stop  = scl_ff_r[1] & scl_d_r & ~sda_d_r & sda_ff_r[1];

endmodule : tws_pin_sync

// [tws_rate_gen.sv]
// Purpose: half-bit tick for master scl generation
// Assumes: OSC_CLKS system clocks per oscillator period
// Notes:   select 7 uses TMR_DIV in place of the timer reload
`timescale 1ns/1ps
`include "tws_regs.svh"
module tws_rate_gen #(
	parameter int unsigned OSC_CLKS = 1,
	parameter int unsigned TMR_DIV  = 96
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic       run_i,
	input  wire logic [2:0] sel_i,
	output logic            tick_o
);
	logic [15:0] cnt_r;
	wire  [15:0] half;

	function automatic logic [11:0] div_of(input logic [2:0] sel);
		case (sel)
			3'h0:    div_of = `TWS_DIV_0;
			3'h1:    div_of = `TWS_DIV_1;
			3'h2:    div_of = `TWS_DIV_2;
			3'h3:    div_of = `TWS_DIV_3;
			3'h4:    div_of = `TWS_DIV_4;
			3'h5:    div_of = `TWS_DIV_5;
			3'h6:    div_of = `TWS_DIV_6;
			default: div_of = 12'(TMR_DIV);
		endcase
	endfunction : div_of

	assign half = 16'((32'(div_of(sel_i)) * OSC_CLKS) >> 1);

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i | (ce_i & ~run_i))
		begin
			cnt_r  <= 16'h0000;
			tick_o <= 1'b0;
		end
		else if (ce_i)
		begin
			tick_o <= (cnt_r >= half - 16'h0001);
			cnt_r  <= (cnt_r >= half - 16'h0001) ? 16'h0000
			                                      : cnt_r + 16'h0001;
		end
	end

endmodule : tws_rate_gen

// [tws_core.sv]
// Purpose: two-wire serial unit, slave receiver and master transmitter/receiver
// Assumes: avalon-mm slave with waitrequest, open-drain scl/sda pins
// Notes:   slave transmitter is not provided; own address + read is
//          left unacknowledged
`timescale 1ns/1ps
`include "tws_regs.svh"

// Notes on behaviour
// - own address bits 7..1 are the seven-bit slave address
// - own address bit 0 enables answering general call 00H
// - bit-rate selection is used only while acting as master
// - nothing runs unless the interface enable bit is one
// - slave reception starts only on own address with write bit or on general call
// - after own address plus write, flag set with valid status
// - arbitration lost then addressed for write gives 68H or 78H
// - acknowledge cleared gives not-acknowledge after next data byte
// - acknowledge cleared ignores addresses; bus still watched
// - at 08H loaded address is sent and acknowledge sampled
// - at 10H address plus read switches to master receiving
// - address sent gives 18H/20H, data sent gives 28H/30H
// - at 18H-30H plain flag clear sends loaded byte
// - at 18H-30H flag clear with start gives repeated start
// - at 18H-30H flag clear with stop sends stop, clears stop bit
// - start and stop together: stop then start, stop bit cleared
// - arbitration loss reports 38H; plain clear releases the bus
// - at 38H clear with start waits for free bus then starts
// - bus transfer stays suspended while the flag is set
// - status read-only, low three bits zero, F8H when idle
// - status follows the flag one clock later, both ways
module tws_core #(
	parameter int unsigned OSC_CLKS = 1,
	parameter int unsigned TMR_DIV  = 96
) (
	input  wire logic                clk_sys_i,
	input  wire logic                rst_i,
	input  wire logic                ce_i,
	input  wire logic [`TWS_AW-1:0]  avs_address_i,
	input  wire logic                avs_read_i,
	input  wire logic                avs_write_i,
	input  wire logic [31:0]         avs_writedata_i,
	input  wire logic [3:0]          avs_byteenable_i,
	output logic      [31:0]         avs_readdata_o,
	output logic                     avs_waitrequest_o,
	input  wire logic                scl_i,
	output logic                     scl_o,
	output logic                     scl_oe_n_o,
	input  wire logic                sda_i,
	output logic                     sda_o,
	output logic                     sda_oe_n_o
);
	tws_pkg::tws_ctl_t   ctl_r;
	tws_pkg::tws_ctl_t   ctl_sw;
	tws_pkg::tws_ctl_t   ctl_nxt;
	tws_pkg::tws_ctl_t   wctl;
	tws_pkg::tws_ev_t    ev;
	tws_pkg::tws_state_t st_r;

	logic [7:0] own_r;
	logic [7:0] dat_r;
	logic [7:0] code_r;
	logic [7:0] stat_r;
	logic [3:0] cnt_r;
	logic       ph_r;
	logic       master_r;
	logic       xmit_r;
	logic       addr_ph_r;
	logic       slave_r;
	logic       gc_r;
	logic       arb_r;
	logic       ack_r;
	logic       rs_r;
	logic       busy_r;
	logic       si_set_r;
	logic       sto_clr_r;
	logic       lvl_r;
	logic       tick;

	// status code once a ninth bit has been clocked
	function automatic logic [7:0] done_code(
		input logic m,
		input logic ap,
		input logic xm,
		input logic dir,
		input logic ack,
		input logic gc,
		input logic arb,
		input logic ackg
	);
		if (m & ap)
			done_code = dir ? (ack ? `TWS_ST_AR_ACK : `TWS_ST_AR_NACK)
			                : (ack ? `TWS_ST_AW_ACK : `TWS_ST_AW_NACK);
		else if (m)
			done_code = xm ? (ack ? `TWS_ST_DT_ACK : `TWS_ST_DT_NACK)
			               : (ackg ? `TWS_ST_DR_ACK : `TWS_ST_DR_NACK);
		else if (ap)
			done_code = gc ? (arb ? `TWS_ST_GC_ARB : `TWS_ST_GC)
			               : (arb ? `TWS_ST_SW_ARB : `TWS_ST_SW);
		else
			done_code = gc ? (ackg ? `TWS_ST_GD_ACK : `TWS_ST_GD_NACK)
			               : (ackg ? `TWS_ST_SD_ACK : `TWS_ST_SD_NACK);
	endfunction : done_code

	tws_pin_sync u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.ev_o      (ev)
	);

	// divider idles unless master, so slave timing ignores it
	tws_rate_gen #(
		.OSC_CLKS (OSC_CLKS),
		.TMR_DIV  (TMR_DIV)
	) u_rate (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.run_i     (master_r),
		.sel_i     ({ctl_r.cr2, ctl_r.cr1, ctl_r.cr0}),
		.tick_o    (tick)
	);

	// bus decode; a request is taken in its second cycle
	wire       req     = avs_read_i | avs_write_i;
	wire       acc     = req & ~avs_waitrequest_o;
	wire       wr      = acc & avs_write_i & avs_byteenable_i[0];
	wire [7:0] wd      = avs_writedata_i[7:0];
	wire       sel_ctl = avs_address_i == `TWS_OFS_CTL;
	wire       sel_st  = avs_address_i == `TWS_OFS_STAT;
	wire       sel_dat = avs_address_i == `TWS_OFS_DAT;
	wire       sel_own = avs_address_i == `TWS_OFS_OWN;
	wire       ctl_wr  = wr & sel_ctl;
	wire       dat_wr  = wr & sel_dat;
	wire       own_wr  = wr & sel_own;
	wire [7:0] rd_mux  = sel_ctl ? ctl_r :
	                     sel_st  ? stat_r :
	                     sel_dat ? dat_r :
	                     sel_own ? own_r : 8'h00;

	assign wctl = wd;

	// stored start/stop bits act once the flag is low; a master waits
	// for its own scl low so that sda never moves while scl is high
	wire resume = (st_r == tws_pkg::S_HOLD) & ~ctl_r.si & ~si_set_r &
	              (~master_r | ~scl_oe_n_o);

	// hardware set wins over a same-cycle software clear
	wire si_nxt = si_set_r | (ctl_r.si & ~(ctl_wr & ~wctl.si));

	assign ctl_sw  = ctl_wr ? wctl : ctl_r;
	assign ctl_nxt = {ctl_sw.cr2, ctl_sw.en, ctl_sw.start_request,
	                  ctl_sw.stop_request & ~sto_clr_r, si_nxt,
	                  ctl_sw.aa, ctl_sw.cr1, ctl_sw.cr0};

	// address match on the byte held after eight shifts
	wire own_hit = (dat_r[7:1] == own_r[7:1]) & ~dat_r[0];
	wire gc_hit  = (dat_r == `TWS_GC_ADDR) & own_r[0];
	wire addr_ok = ctl_r.aa & (own_hit | gc_hit);
	wire last    = cnt_r == `TWS_BIT_LAST;
	wire sda_rel_low = sda_oe_n_o;
	wire lost    = master_r & xmit_r & sda_rel_low & ~ev.sda & ~last;
	wire is_sc   = (code_r == `TWS_ST_START) | (code_r == `TWS_ST_RSTART);
	wire slv_end = code_r[7] & code_r[3];

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
			ctl_r             <= `TWS_CTL_RST;
			own_r             <= `TWS_OWN_RST;
			stat_r            <= `TWS_ST_NONE;
			lvl_r             <= 1'b0;
		end
		else if (ce_i)
		begin
			avs_waitrequest_o <= ~(req & avs_waitrequest_o);
			avs_readdata_o    <= {24'h00_0000, rd_mux};
			ctl_r             <= ctl_nxt;
			own_r             <= own_wr ? wd : own_r;
			// low three bits forced zero; idle code while flag low
			stat_r <= ctl_r.si ? {code_r[7:3], 3'h0}
			                   : `TWS_ST_NONE;
		end
	end

	assign scl_o = lvl_r;
	assign sda_o = lvl_r;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			st_r       <= tws_pkg::S_IDLE;
			dat_r      <= `TWS_DAT_RST;
			code_r     <= `TWS_ST_NONE;
			cnt_r      <= 4'h0;
			ph_r       <= 1'b0;
			master_r   <= 1'b0;
			xmit_r     <= 1'b0;
			addr_ph_r  <= 1'b0;
			slave_r    <= 1'b0;
			gc_r       <= 1'b0;
			arb_r      <= 1'b0;
			ack_r      <= 1'b0;
			rs_r       <= 1'b0;
			busy_r     <= 1'b0;
			si_set_r   <= 1'b0;
			sto_clr_r  <= 1'b0;
			scl_oe_n_o <= 1'b1;
			sda_oe_n_o <= 1'b1;
		end
		else if (ce_i)
		begin
			si_set_r  <= 1'b0;
			sto_clr_r <= 1'b0;
			if (dat_wr)
				dat_r <= wd;
			if (ev.start)
				busy_r <= 1'b1;
			else if (ev.stop)
				busy_r <= 1'b0;
			if (~ctl_r.en)
			begin
				// disabled: off the bus, no flags
				st_r       <= tws_pkg::S_IDLE;
				master_r   <= 1'b0;
				slave_r    <= 1'b0;
				scl_oe_n_o <= 1'b1;
				sda_oe_n_o <= 1'b1;
			end
			else
			case (st_r)
			tws_pkg::S_IDLE:
				// pending start waits for a free bus
				if (ctl_r.start_request & ~busy_r & ~ctl_r.si)
				begin
					master_r   <= 1'b1;
					rs_r       <= 1'b0;
					arb_r      <= 1'b0;
					sda_oe_n_o <= 1'b0;
					st_r       <= tws_pkg::S_START;
				end
				else if (ev.start)
				begin
					st_r      <= tws_pkg::S_BYTE;
					cnt_r     <= 4'h0;
					addr_ph_r <= 1'b1;
					slave_r   <= 1'b0;
					arb_r     <= 1'b0;
					xmit_r    <= 1'b0;
				end
			tws_pkg::S_START:
				if (tick)
				begin
					scl_oe_n_o <= 1'b0;
					code_r     <= rs_r ? `TWS_ST_RSTART : `TWS_ST_START;
					si_set_r   <= 1'b1;
					st_r       <= tws_pkg::S_HOLD;
				end
			tws_pkg::S_RSTART:
				if (~ph_r & tick)
				begin
					scl_oe_n_o <= 1'b1;
					ph_r       <= 1'b1;
				end
				else if (ph_r & tick & ev.scl)
				begin
					sda_oe_n_o <= 1'b0;
					rs_r       <= 1'b1;
					st_r       <= tws_pkg::S_START;
				end
			tws_pkg::S_STOP:
				if (~ph_r & tick)
				begin
					scl_oe_n_o <= 1'b1;
					ph_r       <= 1'b1;
				end
				else if (ph_r & tick & ev.scl)
				begin
					// sta left set runs a fresh start once free
					sda_oe_n_o <= 1'b1;
					master_r   <= 1'b0;
					sto_clr_r  <= 1'b1;
					st_r       <= tws_pkg::S_IDLE;
				end
			tws_pkg::S_HOLD:
			begin
				// scl kept low until the flag clears
				if (master_r & tick & scl_oe_n_o & ev.scl)
					scl_oe_n_o <= 1'b0;
				if (ev.fall)
				begin
					sda_oe_n_o <= 1'b1;
					if (~master_r)
						scl_oe_n_o <= 1'b0;
				end
				if (resume)
				begin
					ph_r  <= 1'b0;
					cnt_r <= 4'h0;
					if (is_sc)
					begin
						addr_ph_r  <= 1'b1;
						xmit_r     <= 1'b1;
						sda_oe_n_o <= dat_r[7];
						st_r       <= tws_pkg::S_BYTE;
					end
					else if (code_r == `TWS_ST_ARB)
					begin
						// leaving the bus: the stretch must go too
						scl_oe_n_o <= 1'b1;
						st_r       <= tws_pkg::S_IDLE;
					end
					else if (~master_r & slv_end)
					begin
						scl_oe_n_o <= 1'b1;
						slave_r    <= 1'b0;
						st_r       <= tws_pkg::S_IDLE;
					end
					else if (~master_r)
					begin
						addr_ph_r  <= 1'b0;
						scl_oe_n_o <= 1'b1;
						st_r       <= tws_pkg::S_BYTE;
					end
					else if (ctl_r.stop_request)
					begin
						sda_oe_n_o <= 1'b0;
						st_r       <= tws_pkg::S_STOP;
					end
					else if (ctl_r.start_request)
					begin
						sda_oe_n_o <= 1'b1;
						st_r       <= tws_pkg::S_RSTART;
					end
					else
					begin
						addr_ph_r  <= 1'b0;
						sda_oe_n_o <= ~xmit_r | dat_r[7];
						st_r       <= tws_pkg::S_BYTE;
					end
				end
			end
			tws_pkg::S_BYTE:
			begin
				if (master_r & tick)
					scl_oe_n_o <= ~scl_oe_n_o | ~ev.scl;
				if (ev.rise & lost)
				begin
					// drop to listener; this byte still decodes
					master_r   <= 1'b0;
					arb_r      <= 1'b1;
					scl_oe_n_o <= 1'b1;
					sda_oe_n_o <= 1'b1;
				end
				if (ev.rise & ~last)
				begin
					dat_r <= {dat_r[6:0], ev.sda};
					cnt_r <= cnt_r + 4'h1;
				end
				else if (ev.rise & (master_r | slave_r))
				begin
					code_r <= done_code(master_r, addr_ph_r, xmit_r,
					                    dat_r[0], ~ev.sda, gc_r,
					                    arb_r, ack_r);
					si_set_r <= 1'b1;
					st_r     <= tws_pkg::S_HOLD;
					if (master_r & addr_ph_r)
						xmit_r <= ~dat_r[0];
				end
				else if (ev.rise & arb_r)
				begin
					code_r   <= `TWS_ST_ARB;
					si_set_r <= 1'b1;
					st_r     <= tws_pkg::S_HOLD;
				end
				else if (ev.rise)
					st_r <= tws_pkg::S_IDLE;
				if (ev.fall & ~last)
					sda_oe_n_o <= ~(master_r & xmit_r) | dat_r[7];
				else if (ev.fall & master_r)
				begin
					ack_r      <= ~xmit_r & ctl_r.aa;
					sda_oe_n_o <= xmit_r | ~ctl_r.aa;
				end
				else if (ev.fall & addr_ph_r & addr_ok)
				begin
					slave_r    <= 1'b1;
					gc_r       <= gc_hit & ~own_hit;
					ack_r      <= 1'b1;
					sda_oe_n_o <= 1'b0;
				end
				else if (ev.fall & ~addr_ph_r & slave_r)
				begin
					ack_r      <= ctl_r.aa;
					sda_oe_n_o <= ~ctl_r.aa;
				end
				if (~master_r & ev.stop)
				begin
					slave_r <= 1'b0;
					st_r    <= tws_pkg::S_IDLE;
				end
				else if (~master_r & ev.start)
				begin
					cnt_r     <= 4'h0;
					addr_ph_r <= 1'b1;
					slave_r   <= 1'b0;
				end
			end
			default:
				st_r <= tws_pkg::S_IDLE;
			endcase
		end
	end

endmodule : tws_core

// [tws_core_sva.sv]
// Purpose: port-level checks of the two-wire serial unit
// Assumes: ce_i high; control bits shadowed from taken writes
// Notes:   master activity is never checked as slave behaviour
`timescale 1ns/1ps
`include "tws_regs.svh"
module tws_core_sva #(
	parameter int unsigned OSC_CLKS = 1,
	parameter int unsigned TMR_DIV  = 96
) (
	input wire logic               clk_sys_i,
	input wire logic               rst_i,
	input wire logic               ce_i,
	input wire logic [`TWS_AW-1:0] avs_address_i,
	input wire logic               avs_read_i,
	input wire logic               avs_write_i,
	input wire logic [31:0]        avs_writedata_i,
	input wire logic [3:0]         avs_byteenable_i,
	input wire logic [31:0]        avs_readdata_o,
	input wire logic               avs_waitrequest_o,
	input wire logic               scl_i,
	input wire logic               scl_oe_n_o,
	input wire logic               sda_oe_n_o
);
	logic              en_r;
	logic              aa_r;
	logic              mst_r;
	logic [3:0]        since_r;
	tws_pkg::tws_ctl_t wctl;
	wire ctl_wr = avs_write_i && !avs_waitrequest_o &&
		avs_byteenable_i[0] && avs_address_i == `TWS_OFS_CTL;
	wire stat_rd = avs_read_i && !avs_waitrequest_o &&
		avs_address_i == `TWS_OFS_STAT;
	assign wctl = avs_writedata_i[7:0];
	// once master, stays so: slave checks would misread master drive
	always_ff @(posedge clk_sys_i)
		if (rst_i)
		begin
			en_r  <= 1'b0;
			aa_r  <= 1'b0;
			mst_r <= 1'b0;
		end
		else if (ctl_wr)
		begin
			en_r  <= wctl.en;
			aa_r  <= wctl.aa;
			mst_r <= mst_r | wctl.start_request;
		end
	always_ff @(posedge clk_sys_i)
		if (rst_i || ctl_wr)
			since_r <= 4'h0;
		else if (since_r != 4'hF)
			since_r <= since_r + 4'h1;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	req_answer_a: assert property (
		ce_i && $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
		else $error("request not answered next cycle");
	wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	stat_bits_a: assert property (stat_rd |->
		avs_readdata_o[2:0] == 3'h0 && avs_readdata_o[31:8] == 24'h0)
		else $error("status low or upper bits not zero");
	unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o &&
		avs_address_i[4] |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	off_idle_a: assert property (!en_r && !$past(en_r) |->
		sda_oe_n_o && scl_oe_n_o)
		else $error("pins driven while disabled");
	noack_aa_a: assert property (!aa_r && !$past(aa_r) && !mst_r |->
		sda_oe_n_o)
		else $error("data line driven with acknowledge off");
	stretch_rel_a: assert property ($rose(scl_oe_n_o) && !mst_r |->
		since_r < 4'h4)
		else $error("clock released without a control write");
	ack_low_a: assert property ($fell(sda_oe_n_o) && !mst_r |->
		!scl_i)
		else $error("slave pulled data while clock high");
	cover property (stat_rd && avs_readdata_o[7:0] == `TWS_ST_SW);
	cover property ($rose(scl_oe_n_o) && !mst_r);
	cover property (mst_r && $fell(sda_oe_n_o) && scl_i);
endmodule : tws_core_sva

bind tws_core tws_core_sva #(.OSC_CLKS(OSC_CLKS), .TMR_DIV(TMR_DIV))
	tws_core_sva_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl_i),
	.scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o));

// [tws_bus_model.sv]
// Purpose: far-side party: master for slave tests, acking slave
// Assumes: lines pulled up; a pull output of 1 drives the line low
// Notes:   link clock 64 ns, still outside frames
`timescale 1ns/1ps
module tws_bus_model (
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic resp_en_i,
	input  wire logic resp_ack_i,
	output logic      scl_pull_o,
	output logic      sda_pull_o
);
	int cnt = 0;
	initial
	begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
	end
	task automatic hi_wait;
		for (int n = 0; n < 5000 && scl_i !== 1'b1; n++)
			#4;
	endtask : hi_wait
	task automatic bit_x(input logic b, output logic r);
		sda_pull_o = ~b;
		#16;
		scl_pull_o = 1'b0;
		hi_wait();
		#16;
		r = sda_i;
		#16;
		scl_pull_o = 1'b1;
		#16;
	endtask : bit_x
	task automatic byte_x(input logic [7:0] d, output logic nk);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, nk);
	endtask : byte_x
	// odd offset keeps the link out of phase with the system clock
	task automatic begin_f;
		#1.3;
		sda_pull_o = 1'b1;
		#32;
		scl_pull_o = 1'b1;
		#16;
	endtask : begin_f
	task automatic end_f;
		sda_pull_o = 1'b1;
		#16;
		scl_pull_o = 1'b0;
		hi_wait();
		#16;
		sda_pull_o = 1'b0;
		#32;
	endtask : end_f
	always @(negedge sda_i)
		if (scl_i === 1'b1)
			cnt = 0;
	always @(negedge scl_i)
		if (resp_en_i)
		begin
			cnt = cnt + 1;
			if (cnt == 9)
				sda_pull_o = resp_ack_i;
			else if (cnt >= 10)
			begin
				sda_pull_o = 1'b0;
				cnt = 1;
			end
		end
endmodule : tws_bus_model

// [tws_core_test.sv]
// Purpose: register and bus tests of the two-wire serial unit
// Assumes: model plays far-side master and acking slave
// Notes:   all waits are bounded loops except the waitrequest wait in bus
`timescale 1ns/1ps
`include "tws_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
	bad_count++; $display("unexpected at %0t got %h exp %h", \
	$time, (g), (e)); end end
module tws_core_test;
	logic        clk_sys_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic [4:0]  adr       = 5'h00;
	logic        rd        = 1'b0;
	logic        wr        = 1'b0;
	logic [31:0] wdat      = 32'h0;
	logic        rsp_en    = 1'b0;
	logic        rsp_ack   = 1'b0;
	logic [31:0] rdat;
	logic        wreq, scl_od, sda_od, scl_oe_n, sda_oe_n, m_scl, m_sda;
	wire         scl = scl_oe_n & ~m_scl;
	wire         sda = sda_oe_n & ~m_sda;
	int          bad_count = 0;
	int          tests_run = 0;
	logic [7:0]  q;
	logic        nk;
	tws_core #(.OSC_CLKS(1)) tws_core_inst (.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .ce_i(1'b1), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .scl_i(scl), .scl_o(scl_od),
		.scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(sda_od),
		.sda_oe_n_o(sda_oe_n));
	tws_bus_model tws_bus_model_inst (.scl_i(scl), .sda_i(sda),
		.resp_en_i(rsp_en), .resp_ack_i(rsp_ack), .scl_pull_o(m_scl),
		.sda_pull_o(m_sda));
	always #2 clk_sys_i = ~clk_sys_i;
	task automatic final_report;
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [7:0] d, output logic [7:0] r);
		@(posedge clk_sys_i);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do
			@(posedge clk_sys_i);
		while (wreq !== 1'b0);
		r = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask : rd_chk
	task automatic poll(input logic [4:0] a, input logic [7:0] e);
		int n;
		n = 0;
		do
		begin
			bus(1'b0, a, 8'h00, q);
			n++;
		end
		while (q !== e && n < 2000);
		`CHK(q, e)
	endtask : poll
	task automatic send(input logic [7:0] d, input logic e);
		tws_bus_model_inst.byte_x(d, nk);
		`CHK(nk, e)
	endtask : send
	task automatic miss(input logic [7:0] a);
		tws_bus_model_inst.begin_f();
		send(a, 1'b1);
		tws_bus_model_inst.end_f();
	endtask : miss
	// the clock stays stretched until the control write clears the flag
	task automatic hit(input logic [7:0] a, input logic [7:0] c);
		tws_bus_model_inst.begin_f();
		send(a, 1'b0);
		poll(`TWS_OFS_STAT, c);
		`CHK(scl_oe_n, 1'b0)
		bus(1'b1, `TWS_OFS_CTL, 8'hC7, q);
		tws_bus_model_inst.end_f();
	endtask : hit
	task automatic mtx(input logic [7:0] d, input logic [7:0] c,
		input logic [7:0] e);
		bus(1'b1, `TWS_OFS_DAT, d, q);
		bus(1'b1, `TWS_OFS_CTL, c, q);
		poll(`TWS_OFS_STAT, e);
	endtask : mtx
	// whole run is near 20 us; the limit leaves wide margin
	initial
	begin
		#300000;
		bad_count++;
		final_report();
	end
	initial
	begin
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rd_chk(`TWS_OFS_CTL, `TWS_CTL_RST);
		rd_chk(`TWS_OFS_STAT, `TWS_ST_NONE);
		rd_chk(`TWS_OFS_DAT, `TWS_DAT_RST);
		rd_chk(`TWS_OFS_OWN, `TWS_OWN_RST);
		bus(1'b1, `TWS_OFS_STAT, 8'h00, q);
		rd_chk(`TWS_OFS_STAT, `TWS_ST_NONE);
		bus(1'b1, 5'h10, 8'h5A, q);
		rd_chk(5'h10, 8'h00);
		bus(1'b1, `TWS_OFS_OWN, 8'h54, q);
		rd_chk(`TWS_OFS_OWN, 8'h54);
		miss(8'h54);
		bus(1'b1, `TWS_OFS_CTL, 8'h44, q);
		miss(8'h55);
		miss(8'h56);
		tws_bus_model_inst.begin_f();
		send(8'h54, 1'b0);
		poll(`TWS_OFS_STAT, `TWS_ST_SW);
		`CHK(scl_oe_n, 1'b0)
		bus(1'b1, `TWS_OFS_CTL, 8'h44, q);
		send(8'hA5, 1'b0);
		poll(`TWS_OFS_STAT, `TWS_ST_SD_ACK);
		rd_chk(`TWS_OFS_DAT, 8'hA5);
		bus(1'b1, `TWS_OFS_CTL, 8'h40, q);
		send(8'h3C, 1'b1);
		poll(`TWS_OFS_STAT, `TWS_ST_SD_NACK);
		`CHK({scl_od, sda_od}, 2'h0)
		bus(1'b1, `TWS_OFS_CTL, 8'h40, q);
		tws_bus_model_inst.end_f();
		miss(8'h54);
		bus(1'b1, `TWS_OFS_CTL, 8'hC7, q);
		hit(8'h54, `TWS_ST_SW);
		miss(8'h00);
		bus(1'b1, `TWS_OFS_OWN, 8'h55, q);
		hit(8'h00, `TWS_ST_GC);
		hit(8'h54, `TWS_ST_SW);
		rsp_en <= 1'b1;
		rsp_ack <= 1'b1;
		bus(1'b1, `TWS_OFS_CTL, 8'hE2, q);
		poll(`TWS_OFS_STAT, `TWS_ST_START);
		mtx(8'hA0, 8'hC2, `TWS_ST_AW_ACK);
		mtx(8'h3C, 8'hC2, `TWS_ST_DT_ACK);
		rsp_ack <= 1'b0;
		mtx(8'h5A, 8'hC2, `TWS_ST_DT_NACK);
		mtx(8'h5A, 8'hE2, `TWS_ST_RSTART);
		mtx(8'hA0, 8'hC2, `TWS_ST_AW_NACK);
		rsp_ack <= 1'b1;
		mtx(8'hA0, 8'hF2, `TWS_ST_START);
		bus(1'b0, `TWS_OFS_CTL, 8'h00, q);
		`CHK(q[4], 1'b0)
		mtx(8'hA0, 8'hC2, `TWS_ST_AW_ACK);
		bus(1'b1, `TWS_OFS_CTL, 8'hD2, q);
		poll(`TWS_OFS_CTL, 8'hC2);
		rd_chk(`TWS_OFS_STAT, `TWS_ST_NONE);
		final_report();
	end
endmodule : tws_core_test
